// File: hw/ptm_pkg.sv
// Package of register map, field layout and reset values for the period timer
package ptm_pkg;
    // ------------------------------------------------------------------
    // Register word indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_TICK_COUNT   = 8'h11;
    localparam logic [7:0] IDX_TIMER_CTRL   = 8'h12;
    localparam logic [7:0] IDX_PERIOD_MATCH = 8'h13;
    localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_IN_DIV_LSB  = 0;
    localparam int CTRL_RUN_BIT     = 2;
    localparam int CTRL_OUT_DIV_LSB = 3;
    localparam int FLAG_MATCH_BIT   = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_TICK_COUNT   = 8'h00;
    localparam logic [6:0] RST_TIMER_CTRL   = 7'h00;
    localparam logic [7:0] RST_PERIOD_MATCH = 8'hFF;

    // ------------------------------------------------------------------
    // Timing: instruction clock is oscillator divided by four
    // ------------------------------------------------------------------
    localparam int          INSTR_CLK_DIV  = 4;
    localparam logic [1:0]  INSTR_DIV_LAST = 2'(INSTR_CLK_DIV - 1);
    localparam logic [3:0]  PRE_LAST_X1    = 4'h0;
    localparam logic [3:0]  PRE_LAST_X4    = 4'h3;
    localparam logic [3:0]  PRE_LAST_X16   = 4'hF;
endpackage : ptm_pkg

// File: hw/ptm_scale_if.sv
// Interface between the timer core and its scaler counters
`timescale 1ns/1ps
`default_nettype none
interface ptm_scale_if;
    logic       clear;   // Clear prescaler and postscaler counts
    logic       tick;    // Instruction clock enable, timer running
    logic [1:0] in_sel;  // Input divide select
    logic [3:0] out_sel; // Output divide select
    logic       pre_out; // Prescaled increment enable
    logic       match;   // Period match pulse
    logic       post_out;// Postscaled match pulse

    modport core  (output clear, tick, in_sel, out_sel, match,
                   input pre_out, post_out);
    modport scale (input clear, tick, in_sel, out_sel, match,
                   output pre_out, post_out);
endinterface : ptm_scale_if
`default_nettype wire

// File: hw/ptm_prescale.sv
// Prescaler counter feeding the tick counter
`timescale 1ns/1ps
`default_nettype none
module ptm_prescale (
    // Clock and reset
    input  wire logic  i_mclk,
    input  wire logic  i_sys_rst,
    // Core link
    ptm_scale_if.scale sif
);
    logic [3:0] pre_q;
    logic [3:0] pre_d;
    logic [3:0] pre_last;
    logic       pre_hit;

    // Ratio decode: 00 gives 1:1, 01 gives 1:4, 1x gives 1:16
    assign pre_last = sif.in_sel[1] ? ptm_pkg::PRE_LAST_X16 :
                      sif.in_sel[0] ? ptm_pkg::PRE_LAST_X4 : ptm_pkg::PRE_LAST_X1;
    assign pre_hit     = sif.tick && (pre_q >= pre_last);
    assign sif.pre_out = pre_hit;
    assign pre_d       = sif.clear ? 4'h0 :
                         pre_hit ? 4'h0 : sif.tick ? pre_q + 4'h1 : pre_q;

    // Prescale count register
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) pre_q <= 4'h0;
        else pre_q <= pre_d;
    end

    // The count only moves on a tick or a clear, so look at the count itself, not its past
    a_pre_ratio16: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (sif.pre_out && sif.in_sel[1]) |-> pre_q == ptm_pkg::PRE_LAST_X16)
        else $error("prescale 1:16 output early");
endmodule : ptm_prescale
`default_nettype wire

// File: hw/ptm_timer.sv
// Period timer with prescaler, postscaler and AHB-Lite register slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module ptm_timer (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Timer outputs
    output logic             o_match_to_serial,
    output logic             o_match_flag
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]  tick_count_q;
    logic [7:0]  tick_count_d;
    logic [7:0]  period_match_value_q;
    logic [6:0]  timer_control_q;
    logic        match_flag_q;
    logic        match_flag_d;
    logic [1:0]  instr_div_q;
    logic        ph_wr_q;
    logic [7:0]  ph_idx_q;
    logic [31:0] rdata_q;

    ptm_scale_if sif ();

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    function automatic logic [7:0] word_index(input logic [31:0] addr);
        word_index = addr[9:2];
    endfunction : word_index

    logic       addr_take;
    logic [7:0] addr_idx;
    logic       wr_now;
    logic       wr_tick;
    logic       wr_ctrl;
    logic       wr_period;
    logic       wr_flags;
    logic [7:0] wbyte;

    // Address phase capture and data phase write strobes
    assign addr_take = i_hsel && i_hready && i_htrans[1];
    assign addr_idx  = word_index(i_haddr);
    assign wr_now    = ph_wr_q;
    assign wbyte     = i_hwdata[7:0];
    assign wr_tick   = wr_now && (ph_idx_q == ptm_pkg::IDX_TICK_COUNT);
    assign wr_ctrl   = wr_now && (ph_idx_q == ptm_pkg::IDX_TIMER_CTRL);
    assign wr_period = wr_now && (ph_idx_q == ptm_pkg::IDX_PERIOD_MATCH);
    assign wr_flags  = wr_now && (ph_idx_q == ptm_pkg::IDX_PERIPH_FLAGS);

    // Zero-wait OKAY slave
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = rdata_q;

    // Address phase register
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ph_wr_q  <= 1'b0;
            ph_idx_q <= 8'h00;
        end else begin
            ph_wr_q  <= addr_take && i_hwrite;
            ph_idx_q <= addr_take ? addr_idx : ph_idx_q;
        end
    end

    // Read mux, unmapped words read zero; bit 7 of control reads zero
    logic [7:0] rd_sel;
    assign rd_sel = (addr_idx == ptm_pkg::IDX_TICK_COUNT)   ? tick_count_q :
                    (addr_idx == ptm_pkg::IDX_TIMER_CTRL)   ? {1'b0, timer_control_q} :
                    (addr_idx == ptm_pkg::IDX_PERIOD_MATCH) ? period_match_value_q :
                    (addr_idx == ptm_pkg::IDX_PERIPH_FLAGS) ?
                        8'(match_flag_q) << ptm_pkg::FLAG_MATCH_BIT : 8'h00;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) rdata_q <= 32'h0000_0000;
        else if (addr_take && !i_hwrite) rdata_q <= {24'h00_0000, rd_sel};
    end

    // ------------------------------------------------------------------
    // Control and period registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            timer_control_q      <= ptm_pkg::RST_TIMER_CTRL;
            period_match_value_q <= ptm_pkg::RST_PERIOD_MATCH;
        end else begin
            if (wr_ctrl) timer_control_q <= wbyte[6:0];
            if (wr_period) period_match_value_q <= wbyte;
        end
    end

    logic       run;
    assign run = timer_control_q[ptm_pkg::CTRL_RUN_BIT];

    // ------------------------------------------------------------------
    // Instruction clock enable: oscillator divided by four
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) instr_div_q <= 2'h0;
        else if (instr_div_q == ptm_pkg::INSTR_DIV_LAST) instr_div_q <= 2'h0;
        else instr_div_q <= instr_div_q + 2'h1;
    end

    // Scaler link signals
    assign sif.tick    = run && (instr_div_q == ptm_pkg::INSTR_DIV_LAST);
    assign sif.clear   = wr_tick || wr_ctrl;
    assign sif.in_sel  = timer_control_q[ptm_pkg::CTRL_IN_DIV_LSB +: 2];
    assign sif.out_sel = timer_control_q[ptm_pkg::CTRL_OUT_DIV_LSB +: 4];

    ptm_prescale u_pre (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .sif       (sif)
    );

    ptm_postscale u_post (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .sif       (sif)
    );

    // ------------------------------------------------------------------
    // Tick counter with period wrap
    // ------------------------------------------------------------------
    logic inc;
    logic at_period;
    assign inc       = sif.pre_out && !sif.clear;
    assign at_period = (tick_count_q == period_match_value_q);
    assign sif.match = inc && at_period;
    assign tick_count_d = wr_tick ? wbyte :
                          !inc ? tick_count_q :
                          at_period ? ptm_pkg::RST_TICK_COUNT :
                          tick_count_q + 8'h01;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) tick_count_q <= ptm_pkg::RST_TICK_COUNT;
        else tick_count_q <= tick_count_d;
    end

    // Serial port shift clock source, registered match pulse
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) o_match_to_serial <= 1'b0;
        else o_match_to_serial <= sif.match;
    end

    // ------------------------------------------------------------------
    // Match flag: set wins over software clear
    // ------------------------------------------------------------------
    assign match_flag_d = sif.post_out ? 1'b1 :
                          wr_flags ? wbyte[ptm_pkg::FLAG_MATCH_BIT] : match_flag_q;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) match_flag_q <= 1'b0;
        else match_flag_q <= match_flag_d;
    end
    assign o_match_flag = match_flag_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_wrap_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sif.match && !wr_tick |=> tick_count_q == 8'h00)
        else $error("counter did not wrap to zero");
    a_count_up: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        inc && !at_period && !wr_tick |=> tick_count_q == $past(tick_count_q) + 8'h01)
        else $error("counter did not step by one");
    a_stop_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !run && !wr_tick |=> $stable(tick_count_q))
        else $error("stopped timer changed count");
    a_ctrl_keeps: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        wr_ctrl && !wr_tick |=> tick_count_q == $past(tick_count_q))
        else $error("control write changed counter");
    a_tick_load: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        wr_tick |=> tick_count_q == $past(wbyte))
        else $error("counter write lost");
    a_bit7_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        addr_take && !i_hwrite && addr_idx == ptm_pkg::IDX_TIMER_CTRL |=> !o_hrdata[7])
        else $error("control bit 7 read as one");
    a_flag_sets: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sif.post_out |=> o_match_flag)
        else $error("flag not set by postscaler");
    a_serial_out: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sif.match |=> o_match_to_serial ##1 !o_match_to_serial || $past(sif.match,1))
        else $error("serial match pulse wrong");
    a_period_rst: assert property (@(posedge i_mclk)
        $fell(i_sys_rst) |-> period_match_value_q == 8'hFF && timer_control_q == 7'h00)
        else $error("reset values wrong");

    c_wrap:     cover property (@(posedge i_mclk) disable iff (i_sys_rst) sif.match);
    c_flag:     cover property (@(posedge i_mclk) disable iff (i_sys_rst) sif.post_out);
    c_ctrl_wr:  cover property (@(posedge i_mclk) disable iff (i_sys_rst) wr_ctrl && run);
    c_pre16:    cover property (@(posedge i_mclk) disable iff (i_sys_rst)
        inc && sif.in_sel[1]);
endmodule : ptm_timer

// Postscaler counting period matches
module ptm_postscale (
    // Clock and reset
    input  wire logic  i_mclk,
    input  wire logic  i_sys_rst,
    // Core link
    ptm_scale_if.scale sif
);
    logic [3:0] post_q;
    logic [3:0] post_d;
    logic       post_hit;

    // Ratio is field plus one; restart after reaching it
    assign post_hit     = sif.match && (post_q >= sif.out_sel);
    assign sif.post_out = post_hit;
    assign post_d       = sif.clear ? 4'h0 :
                          post_hit ? 4'h0 : sif.match ? post_q + 4'h1 : post_q;

    // Postscale count register
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) post_q <= 4'h0;
        else post_q <= post_d;
    end
endmodule : ptm_postscale
`default_nettype wire

// File: tb/ptm_timer_bench.sv
// Self-checking bench for the period timer over its register bus
`timescale 1ns/1ps
`default_nettype none
module ptm_timer_bench;
    // ------------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------------
    localparam int LIMIT = 20000;
    logic        i_mclk;
    logic        i_sys_rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        o_match_to_serial;
    logic        o_match_flag;
    logic [31:0] rdat;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          last_t = 0;
    int          gap = 0;
    int          n_pulse = 0;
    int          n0;
    logic        seen_top;
    logic        seen_zero;
    logic [3:0]  ps_sel [4] = '{4'h0, 4'h1, 4'h5, 4'hF};

    // Byte address of a register word
    function automatic logic [31:0] adr(input logic [7:0] idx);
        adr = {22'h0, idx, 2'b00};
    endfunction : adr

    // ------------------------------------------------------------------
    // Design under test
    // ------------------------------------------------------------------
    ptm_timer u_ptm_timer (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .o_match_to_serial(o_match_to_serial), .o_match_flag(o_match_flag)
    );

    // Clock, 50 ns period
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    // Match pulse monitor and hang guard
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (o_match_to_serial === 1'b1) begin
            gap     <= cyc - last_t;
            last_t  <= cyc;
            n_pulse <= n_pulse + 1;
        end
        if (cyc >= LIMIT) begin
            n_fail = n_fail + 1;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge i_mclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge i_mclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge i_mclk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        bus(1'b1, adr(idx), wd);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, adr(idx), 32'h0);
        check(what, rdat, exp);
        check("response", {31'h0, hresp}, 32'h0);
    endtask : rd

    task automatic reset_values();
        rd(ptm_pkg::IDX_TICK_COUNT, 32'h0000_0000, "tick after reset");
        rd(ptm_pkg::IDX_TIMER_CTRL, 32'h0000_0000, "control after reset");
        rd(ptm_pkg::IDX_PERIOD_MATCH, 32'h0000_00FF, "period after reset");
        rd(ptm_pkg::IDX_PERIPH_FLAGS, 32'h0000_0000, "flags after reset");
        rd(8'h14, 32'h0000_0000, "unmapped word");
    endtask : reset_values

    // Wait for a pulse count, bounded
    task automatic wait_pulses(input int target);
        int k;
        k = 0;
        while (n_pulse < target && k < 2000) begin
            @(posedge i_mclk);
            k++;
        end
        #1;
    endtask : wait_pulses

    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        i_sys_rst = 1'b1;
        hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0;
        repeat (10) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        reset_values();
        // Register access, unimplemented bit, control write keeps count
        wr(ptm_pkg::IDX_PERIOD_MATCH, 32'h0000_00A5);
        rd(ptm_pkg::IDX_PERIOD_MATCH, 32'h0000_00A5, "period rw");
        wr(ptm_pkg::IDX_TICK_COUNT, 32'h0000_0005);
        wr(ptm_pkg::IDX_TIMER_CTRL, 32'h0000_007B);
        rd(ptm_pkg::IDX_TICK_COUNT, 32'h0000_0005, "tick kept");
        rd(ptm_pkg::IDX_TIMER_CTRL, 32'h0000_007B, "control rw");
        wr(ptm_pkg::IDX_TIMER_CTRL, 32'h0000_00F8);
        rd(ptm_pkg::IDX_TIMER_CTRL, 32'h0000_0078, "control bit 7");
        repeat (40) @(posedge i_mclk);
        rd(ptm_pkg::IDX_TICK_COUNT, 32'h0000_0005, "stopped tick");
        // Prescale ratios seen as match pulse spacing, period 2
        wr(ptm_pkg::IDX_PERIOD_MATCH, 32'h0000_0002);
        for (int s = 0; s < 4; s++) begin
            wr(ptm_pkg::IDX_TIMER_CTRL, {29'h0, 1'b1, 2'(s)});
            n0 = n_pulse;
            wait_pulses(n0 + 3);
            check("match gap", 32'(gap), 32'(12 * (s == 0 ? 1 : (s == 1 ? 4 : 16))));
        end
        // Count range with wrap, 1:1
        wr(ptm_pkg::IDX_TIMER_CTRL, 32'h0000_0004);
        seen_top = 1'b0;
        seen_zero = 1'b0;
        for (int i = 0; i < 30; i++) begin
            bus(1'b0, adr(ptm_pkg::IDX_TICK_COUNT), 32'h0);
            check("tick in range", {31'h0, rdat <= 32'h2}, 32'h1);
            if (rdat === 32'h2) seen_top = 1'b1;
            if (rdat === 32'h0) seen_zero = 1'b1;
        end
        check("top and zero seen", {30'h0, seen_top, seen_zero}, 32'h3);
        // Postscale ratios counted in matches, period 1
        wr(ptm_pkg::IDX_PERIOD_MATCH, 32'h0000_0001);
        for (int j = 0; j < 4; j++) begin
            wr(ptm_pkg::IDX_TIMER_CTRL, 32'h0000_0000);
            wr(ptm_pkg::IDX_TICK_COUNT, 32'h0000_0000);
            wr(ptm_pkg::IDX_TIMER_CTRL, {25'h0, ps_sel[j], 1'b1, 2'b00});
            wr(ptm_pkg::IDX_PERIPH_FLAGS, 32'h0000_0000);
            // Let the flag clear settle before watching for the next set
            #1;
            n0 = n_pulse;
            for (int k = 0; k < 1000 && o_match_flag !== 1'b1; k++) @(posedge i_mclk);
            #1;
            check("matches per flag", 32'(n_pulse - n0), 32'(ps_sel[j]) + 32'h1);
            check("flag pin", {31'h0, o_match_flag}, 32'h1);
            rd(ptm_pkg::IDX_PERIPH_FLAGS, 32'h0000_0002, "flag word");
        end
        // Second reset while running
        @(posedge i_mclk);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        reset_values();
        close_out();
    end
endmodule : ptm_timer_bench
`default_nettype wire
